// File: core/rfp_phy_port.sv
`timescale 1ns/100ps
`include "rfp_cfg.svh"
// Operation
// (RULE_01) all clocks come from 25MHz source or external 50MHz per clock mode
// (RULE_02) negotiation picks best common: 100 full, 100 half, 10 full, 10 half
// (RULE_03) without partner negotiation, mode follows parallel detection at receiver
// (RULE_04) negotiation on after reset, then control 0 bit 12 switches it
// (RULE_05) forced mode takes speed from bit 13, duplex from bit 8
// (RULE_06) independent 2-bit transmit and receive groups, 10/100, half/full
// (RULE_07) one continuous 50MHz reference times every interface signal
// (RULE_08) 25MHz mode drives reference out, 50MHz mode takes it in
// (RULE_09) MAC raises transmit enable with first preamble dibit, holds it
// (RULE_10) MAC drops transmit enable before edge after last dibit
// (RULE_11) transmit dibits accepted each reference clock while enable high; at 10 Mb/s the code takes one every tenth reference clock
// (RULE_12) idle transmit data is 00, non-zero idle data ignored
// (RULE_13) carrier sense rises unaligned on carrier, falls on carrier loss
// (RULE_14) carrier/valid stays high through last dibit, low before next edge
// (RULE_15) receive data reads 00 until decoding is ready
// (RULE_16) two recovered bits per reference period while carrier/valid high
// (RULE_17) receive data 00 while carrier/valid low, MAC ignores otherwise
// (RULE_18) receive error raised on a reference edge for detected symbol errors
// (RULE_19) MAC ignores receive error while carrier/valid low
// (RULE_20) MAC makes its own collision from transmit enable and carrier/valid
// (RULE_21) clock control bit 7 swaps away from power-up clock mode
// (RULE_22) strap level latched at reset release into bits 12, 13, advertisement
// (RULE_23) interface signals launched and sampled on reference rising edge
module rfp_phy_port
    import rfp_pkg::*;
#(
    parameter logic REF50_DEFAULT = 1'b0
) (
    input  wire logic          clock,
    input  wire logic          rst,
    input  wire logic          ce,
    input  wire logic [7:0]    s_axi_awaddr,
    input  wire logic          s_axi_awvalid,
    output logic               s_axi_awready,
    input  wire logic [31:0]   s_axi_wdata,
    input  wire logic [3:0]    s_axi_wstrb,
    input  wire logic          s_axi_wvalid,
    output logic               s_axi_wready,
    output logic [1:0]         s_axi_bresp,
    output logic               s_axi_bvalid,
    input  wire logic          s_axi_bready,
    input  wire logic [7:0]    s_axi_araddr,
    input  wire logic          s_axi_arvalid,
    output logic               s_axi_arready,
    output logic [31:0]        s_axi_rdata,
    output logic [1:0]         s_axi_rresp,
    output logic               s_axi_rvalid,
    input  wire logic          s_axi_rready,
    input  wire logic          clock_in_pin,
    output logic               ref_clk_out,
    output logic               ref_clk_oe_n,
    input  wire logic          txen,
    input  wire rfp_dibit_type txd,
    output logic               crs_dv,
    output rfp_dibit_type      rxd,
    output logic               rxer,
    input  wire logic          autoneg_speed_strap,
    input  wire logic          line_carrier,
    input  wire logic          line_rx_dv,
    input  wire rfp_dibit_type line_rx_dibit,
    input  wire logic          line_rx_err,
    input  wire logic          partner_neg,
    input  wire logic [3:0]    partner_abil,
    input  wire logic          pd_100,
    input  wire logic          pd_10,
    output logic               line_tx_en,
    output rfp_dibit_type      line_tx_dibit,
    output logic               link_up,
    output logic               link_speed100,
    output logic               link_full
);

    logic [15:0]   ctrl0_q;
    logic [15:0]   adv_q;
    logic          clk_swap_q;
    logic [7:0]    aw_addr_q;
    logic          aw_held_q;
    logic [31:0]   w_data_q;
    logic [3:0]    w_strb_q;
    logic          w_held_q;
    logic          strap_s1_q;
    logic          strap_s2_q;
    logic          in_rst_q;
    logic [3:0]    tx_s1_q;
    logic [3:0]    tx_s2_q;
    logic          car_s1_q;
    logic          car_s2_q;
    logic [3:0]    div_q;
    rfp_link_type  link_q;
    logic          aneg_done_q;
    logic          mode50;
    logic          tick;
    logic          ref_raw;
    logic          strobe;
    logic [3:0]    common;
    rfp_rsel_type  wsel;
    logic [15:0]   stat;

    // address decode shared by read and write
    function automatic rfp_rsel_type decode(input logic [7:0] a);
        if (a[1:0] != 2'b00) begin
            return RS_NONE;
        end
        case (a[7:2])
            {1'b0, `RFP_IDX_CTRL0}:  return RS_CTRL0;
            {1'b0, `RFP_IDX_ADVERT}: return RS_ADVERT;
            {1'b0, `RFP_IDX_STATUS}: return RS_STATUS;
            {1'b0, `RFP_IDX_CLKCTL}: return RS_CLKCTL;
            default:                 return RS_NONE;
        endcase
    endfunction

    // byte-lane merge for the 16-bit registers
    function automatic logic [15:0] merge(input logic [15:0] old, input logic [31:0] d, input logic [3:0] s);
        return {s[1] ? d[15:8] : old[15:8], s[0] ? d[7:0] : old[7:0]};
    endfunction

    assign mode50 = REF50_DEFAULT ^ clk_swap_q; // RULE_21
    assign wsel   = decode(aw_addr_q);
    assign common = adv_q[`RFP_ADV_LSB +: 4] & partner_abil;
    assign strobe = tick & (link_speed100 | (div_q == 4'h0)); // RULE_06
    assign stat   = {4'h0, partner_abil, 3'h0, mode50, aneg_done_q, link_full, link_speed100, link_up};

    rfp_ref_tick u_tick (
        .clock        (clock),
        .rst          (rst),
        .ce           (ce),
        .mode50       (mode50),
        .clock_in_pin (clock_in_pin),
        .tick         (tick),
        .ref_clk_out  (ref_raw)
    );

    // pin synchronisers
    always_ff @(posedge clock) begin
        if (rst) begin
            strap_s1_q <= autoneg_speed_strap;
            strap_s2_q <= strap_s1_q;
            tx_s1_q    <= 4'h0;
            tx_s2_q    <= 4'h0;
            car_s1_q   <= 1'b0;
            car_s2_q   <= 1'b0;
        end else if (ce) begin
            strap_s1_q <= autoneg_speed_strap;
            strap_s2_q <= strap_s1_q;
            tx_s1_q    <= {1'b0, txen, txd};
            tx_s2_q    <= tx_s1_q;
            car_s1_q   <= line_carrier;
            car_s2_q   <= car_s1_q;
        end
    end

    // reference clock pin drive
    always_ff @(posedge clock) begin
        if (rst) begin
            ref_clk_out  <= 1'b0;
            ref_clk_oe_n <= 1'b1;
        end else if (ce) begin
            ref_clk_out  <= ref_raw & ~mode50; // RULE_08
            ref_clk_oe_n <= mode50; // RULE_08
        end
    end

    // write address and data taken in either order
    always_ff @(posedge clock) begin
        if (rst) begin
            aw_held_q     <= 1'b0;
            w_held_q      <= 1'b0;
            aw_addr_q     <= 8'h00;
            w_data_q      <= 32'h0000_0000;
            w_strb_q      <= 4'h0;
            s_axi_awready <= 1'b0;
            s_axi_wready  <= 1'b0;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= `RFP_RESP_OKAY;
        end else if (ce) begin
            s_axi_awready <= ~aw_held_q & ~(s_axi_awvalid & s_axi_awready) & ~s_axi_bvalid;
            s_axi_wready  <= ~w_held_q & ~(s_axi_wvalid & s_axi_wready) & ~s_axi_bvalid;
            if (s_axi_awvalid & s_axi_awready) begin
                aw_held_q <= 1'b1;
                aw_addr_q <= s_axi_awaddr;
            end
            if (s_axi_wvalid & s_axi_wready) begin
                w_held_q <= 1'b1;
                w_data_q <= s_axi_wdata;
                w_strb_q <= s_axi_wstrb;
            end
            if (aw_held_q & w_held_q & ~s_axi_bvalid) begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= (wsel == RS_NONE) ? `RFP_RESP_SLVERR : `RFP_RESP_OKAY;
                aw_held_q    <= 1'b0;
                w_held_q     <= 1'b0;
            end else if (s_axi_bvalid & s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // register writes and strap capture after reset release
    always_ff @(posedge clock) begin
        if (rst) begin
            ctrl0_q    <= `RFP_CTRL0_RST; // RULE_04
            adv_q      <= `RFP_ADV_RST;
            clk_swap_q <= 1'b0;
            in_rst_q   <= 1'b1;
        end else if (ce) begin
            in_rst_q <= 1'b0;
            if (in_rst_q) begin
                ctrl0_q[`RFP_CTRL0_ANEN]  <= strap_s2_q; // RULE_22
                ctrl0_q[`RFP_CTRL0_SPEED] <= strap_s2_q; // RULE_22
                if (!strap_s2_q) begin
                    adv_q[`RFP_ADV_LSB +: 4] <= `RFP_ADV_10ONLY; // RULE_22
                end
            end else if (aw_held_q & w_held_q & ~s_axi_bvalid) begin
                case (wsel)
                    RS_CTRL0: begin
                        ctrl0_q <= merge(ctrl0_q, w_data_q, w_strb_q) & `RFP_CTRL0_RST; // RULE_04 RULE_05
                    end
                    RS_ADVERT: begin
                        adv_q <= merge(adv_q, w_data_q, w_strb_q) & `RFP_ADV_RST;
                    end
                    RS_CLKCTL: begin
                        if (w_strb_q[0]) begin
                            clk_swap_q <= w_data_q[`RFP_CLK_SWAP]; // RULE_21
                        end
                    end
                    default: begin
                    end
                endcase
            end
        end
    end

    // register reads
    always_ff @(posedge clock) begin
        if (rst) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h0000_0000;
            s_axi_rresp   <= `RFP_RESP_OKAY;
        end else if (ce) begin
            s_axi_arready <= ~s_axi_rvalid & ~(s_axi_arvalid & s_axi_arready);
            if (s_axi_arvalid & s_axi_arready) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rresp  <= `RFP_RESP_OKAY;
                case (decode(s_axi_araddr))
                    RS_CTRL0:  s_axi_rdata <= {16'h0000, ctrl0_q};
                    RS_ADVERT: s_axi_rdata <= {16'h0000, adv_q};
                    RS_STATUS: s_axi_rdata <= {16'h0000, stat};
                    RS_CLKCTL: s_axi_rdata <= {24'h00_0000, clk_swap_q, 7'h00};
                    default: begin
                        s_axi_rdata <= 32'h0000_0000;
                        s_axi_rresp <= `RFP_RESP_SLVERR;
                    end
                endcase
            end else if (s_axi_rvalid & s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end

    // mode resolution: negotiation, parallel detect or forced
    always_ff @(posedge clock) begin
        if (rst) begin
            link_q        <= LK_DOWN;
            link_up       <= 1'b0;
            link_speed100 <= 1'b1;
            link_full     <= 1'b0;
            aneg_done_q   <= 1'b0;
        end else if (ce) begin
            case (link_q)
                LK_DOWN: begin
                    if (!ctrl0_q[`RFP_CTRL0_ANEN]) begin
                        link_speed100 <= ctrl0_q[`RFP_CTRL0_SPEED]; // RULE_05
                        link_full     <= ctrl0_q[`RFP_CTRL0_DUPLEX]; // RULE_05
                        link_up       <= 1'b1;
                        link_q        <= LK_UP;
                    end else if (partner_neg && common != 4'h0) begin
                        link_speed100 <= common[3] | common[2]; // RULE_02
                        link_full     <= common[3] | (~common[2] & common[1]); // RULE_02
                        aneg_done_q   <= 1'b1;
                        link_up       <= 1'b1;
                        link_q        <= LK_UP;
                    end else if (!partner_neg && (pd_100 || pd_10)) begin
                        link_speed100 <= pd_100; // RULE_03
                        link_full     <= 1'b0; // RULE_03
                        link_up       <= 1'b1;
                        link_q        <= LK_UP;
                    end
                end
                LK_UP: begin
                    if (ctrl0_q[`RFP_CTRL0_ANEN] == 1'b0 ? !aneg_done_q && (link_speed100 !=
                        ctrl0_q[`RFP_CTRL0_SPEED] || link_full != ctrl0_q[`RFP_CTRL0_DUPLEX]) || aneg_done_q
                        : (aneg_done_q ? !partner_neg : !(pd_100 || pd_10) || partner_neg)) begin
                        link_up     <= 1'b0;
                        aneg_done_q <= 1'b0;
                        link_q      <= LK_DOWN;
                    end
                end
                default: link_q <= LK_DOWN;
            endcase
        end
    end

    // 10 Mb/s repeats each dibit over ten reference periods
    always_ff @(posedge clock) begin
        if (rst) begin
            div_q <= 4'h0;
        end else if (ce && tick) begin
            div_q <= (div_q == `RFP_DIV10) ? 4'h0 : div_q + 4'h1; // RULE_06
        end
    end

    // transmit path toward the line
    always_ff @(posedge clock) begin
        if (rst) begin
            line_tx_en    <= 1'b0;
            line_tx_dibit <= 2'b00;
        end else if (ce && strobe) begin
            line_tx_en    <= tx_s2_q[2]; // RULE_11 RULE_23
            line_tx_dibit <= tx_s2_q[2] ? tx_s2_q[1:0] : 2'b00; // RULE_11 RULE_12
        end
    end

    // receive path toward the MAC
    always_ff @(posedge clock) begin
        if (rst) begin
            crs_dv <= 1'b0;
            rxd    <= 2'b00;
            rxer   <= 1'b0;
        end else if (ce) begin
            if (car_s2_q && !crs_dv) begin
                crs_dv <= 1'b1; // RULE_13
            end else if (tick && !car_s2_q && !line_rx_dv) begin
                crs_dv <= 1'b0; // RULE_13 RULE_14
            end
            if (tick && !crs_dv) begin
                rxd  <= 2'b00; // RULE_17
                rxer <= 1'b0;
            end else if (strobe) begin
                rxd  <= line_rx_dv ? line_rx_dibit : 2'b00; // RULE_15 RULE_16 RULE_23
                rxer <= line_rx_err & line_rx_dv; // RULE_18
            end
        end
    end

endmodule // rfp_phy_port

// File: core/rfp_ref_tick.sv
`timescale 1ns/100ps
module rfp_ref_tick
    import rfp_pkg::*;
(
    input  wire logic clock,
    input  wire logic rst,
    input  wire logic ce,
    input  wire logic mode50,
    input  wire logic clock_in_pin,
    output logic      tick,
    output logic      ref_clk_out
);

    logic       pin_s1_q;
    logic       pin_s2_q;
    logic       pin_s3_q;
    logic       div_q;

    // two-stage sync of the external reference
    always_ff @(posedge clock) begin
        if (rst) begin
            pin_s1_q <= 1'b0;
            pin_s2_q <= 1'b0;
            pin_s3_q <= 1'b0;
        end else if (ce) begin
            pin_s1_q <= clock_in_pin;
            pin_s2_q <= pin_s1_q;
            pin_s3_q <= pin_s2_q;
        end
    end

    // internal reference divided from our own clock
    always_ff @(posedge clock) begin
        if (rst) begin
            div_q <= 1'b0;
        end else if (ce) begin
            div_q <= ~div_q;
        end
    end

    // reference rising edge of the selected source
    always_ff @(posedge clock) begin
        if (rst) begin
            tick        <= 1'b0;
            ref_clk_out <= 1'b0;
        end else if (ce) begin
            ref_clk_out <= mode50 ? 1'b0 : ~div_q; // RULE_01 RULE_08
            if (mode50) begin
                tick <= pin_s2_q & ~pin_s3_q; // RULE_01 RULE_07
            end else begin
                tick <= ~div_q; // RULE_01 RULE_07
            end
        end else begin
            tick <= 1'b0;
        end
    end

endmodule // rfp_ref_tick

// File: shared/rfp_cfg.svh
`ifndef RFP_CFG_SVH
`define RFP_CFG_SVH

// register indices, byte address is four times the index
`define RFP_IDX_CTRL0     5'h00
`define RFP_IDX_ADVERT    5'h04
`define RFP_IDX_STATUS    5'h10
`define RFP_IDX_CLKCTL    5'h1F

// control register 0 fields
`define RFP_CTRL0_DUPLEX  8
`define RFP_CTRL0_ANEN    12
`define RFP_CTRL0_SPEED   13
`define RFP_CTRL0_RST     16'h3100

// advertisement fields and reset
`define RFP_ADV_LSB       5
`define RFP_ADV_RST       16'h01E1
`define RFP_ADV_10ONLY    4'h3

// clock control field
`define RFP_CLK_SWAP      7

// status fields
`define RFP_ST_LINK       0
`define RFP_ST_SPD100     1
`define RFP_ST_FULL       2
`define RFP_ST_ANEG       3
`define RFP_ST_REF50      4
`define RFP_ST_PART_LSB   8

// last divider count at 10 Mb/s, each dibit repeats ten times
`define RFP_DIV10         4'h9

// bus answer codes
`define RFP_RESP_OKAY     2'h0
`define RFP_RESP_SLVERR   2'h2

`endif

// File: shared/rfp_pkg.sv
package rfp_pkg;

    // register selected by a bus address
    typedef enum logic [2:0] {
        RS_CTRL0,
        RS_ADVERT,
        RS_STATUS,
        RS_CLKCTL,
        RS_NONE
    } rfp_rsel_type;

    // link state of the mode resolver
    typedef enum logic [1:0] {
        LK_DOWN,
        LK_UP
    } rfp_link_type;

    typedef logic [1:0] rfp_dibit_type;

endpackage

// File: verification/rfp_mac_model.sv
`timescale 1ns/100ps
module rfp_mac_model
    import rfp_pkg::*;
(
    input  wire logic          clock,
    input  wire logic          ref_clk,
    input  wire logic          start,
    input  wire logic [15:0]   tx_word,
    input  wire logic          crs_dv,
    input  wire rfp_dibit_type rxd,
    input  wire logic          rxer,
    output logic               txen = 1'b0,
    output rfp_dibit_type      txd = 2'h0,
    output logic [15:0]        rx_word,
    output logic               rx_bad = 1'b0,
    output logic               col
);
    logic        ref_q = 1'b0;
    logic        busy  = 1'b0;
    logic [3:0]  cnt;
    logic [15:0] sh;

    // collision made here
    assign col = txen & crs_dv;

    // one dibit each way per reference rise
    always @(posedge clock) begin
        ref_q <= ref_clk;
        if (start) begin
            busy <= 1'b1;
            sh <= tx_word;
            cnt <= 4'h0;
            rx_bad <= 1'b0;
        end else if (ref_clk && !ref_q) begin
            if (busy && cnt != 4'h8) begin
                txen <= 1'b1;
                txd <= sh[15:14];
                sh <= {sh[13:0], 2'h0};
                cnt <= cnt + 4'h1;
            end else begin
                txen <= 1'b0;
                txd <= 2'h0;
                busy <= 1'b0;
            end
            if (crs_dv) begin
                rx_word <= {rx_word[13:0], rxd};
                rx_bad <= rx_bad | rxer;
            end
        end
    end
endmodule // rfp_mac_model

// File: verification/rfp_phy_port_asserts.sv
`timescale 1ns/100ps
module rfp_phy_port_asserts
    import rfp_pkg::*;
(
    input wire logic          clock,
    input wire logic          rst,
    input wire logic          txen,
    input wire logic          line_carrier,
    input wire logic          line_rx_dv,
    input wire logic          crs_dv,
    input wire rfp_dibit_type rxd,
    input wire logic          rxer,
    input wire logic          line_tx_en,
    input wire rfp_dibit_type line_tx_dibit,
    input wire logic          ref_clk_out,
    input wire logic          ref_clk_oe_n
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (rst);

    // receive and transmit idle, line enable following txen three cycles later
    a_rx_idle_zero: assert property ((!crs_dv) [*8] |-> rxd == 2'h0 && !rxer)
        else $error("rx active while idle");
    a_tx_idle_zero: assert property (!line_tx_en |-> line_tx_dibit == 2'h0)
        else $error("line dibit not idle");
    a_tx_follow_en: assert property (line_tx_en != $past(line_tx_en) |-> line_tx_en == $past(txen, 3))
        else $error("line enable late");
    // reference pin
    a_ref_quiet: assert property (ref_clk_oe_n |-> !ref_clk_out)
        else $error("reference toggles while undriven");
    a_ref_toggle: assert property (!ref_clk_oe_n && !$past(ref_clk_oe_n) |-> ref_clk_out != $past(ref_clk_out))
        else $error("reference output stalled");
    // carrier sense
    a_crs_rise: assert property ($rose(line_carrier) |-> ##[1:4] crs_dv)
        else $error("crs_dv late after carrier");
    a_crs_hold: assert property (crs_dv && line_rx_dv |=> crs_dv)
        else $error("crs_dv dropped inside frame");
    a_crs_drop: assert property ($fell(line_rx_dv) && !line_carrier |-> ##[1:12] !crs_dv)
        else $error("crs_dv stuck high");
endmodule // rfp_phy_port_asserts

bind rfp_phy_port rfp_phy_port_asserts chk_u (
    .clock, .rst, .txen, .line_carrier, .line_rx_dv, .crs_dv, .rxd, .rxer, .line_tx_en, .line_tx_dibit,
    .ref_clk_out, .ref_clk_oe_n
);

// File: verification/testbench.sv
`timescale 1ns/100ps
`include "rfp_cfg.svh"
module testbench
    import rfp_pkg::*;
;
    localparam logic [7:0] A_CTL = {1'b0, `RFP_IDX_CTRL0, 2'h0};
    localparam logic [7:0] A_ADV = {1'b0, `RFP_IDX_ADVERT, 2'h0};
    localparam logic [7:0] A_ST  = {1'b0, `RFP_IDX_STATUS, 2'h0};
    localparam logic [7:0] A_CLK = {1'b0, `RFP_IDX_CLKCTL, 2'h0};
    logic          rst = 1'b1, autoneg_speed_strap = 1'b1, line_carrier = 1'b0, line_rx_dv = 1'b0;
    logic          line_rx_err, partner_neg = 1'b0, pd_100 = 1'b0, pd_10 = 1'b0, mac_start = 1'b0;
    logic          s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic          s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, clock, clock_in_pin;
    logic          s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, mac_rx_bad;
    logic          ref_clk_out, ref_clk_oe_n, txen, crs_dv, rxer, line_tx_en, mac_col;
    logic          link_up, link_speed100, link_full;
    logic [1:0]    s_axi_bresp, s_axi_rresp, rsp;
    logic [3:0]    partner_abil = 4'h0;
    logic [7:0]    s_axi_awaddr, s_axi_araddr;
    logic [15:0]   mac_tx_word, mac_rx_word;
    logic [31:0]   s_axi_wdata, s_axi_rdata, rd;
    rfp_dibit_type txd, rxd, line_tx_dibit, line_rx_dibit;
    int            error_cnt = 0, checked = 0, cyc = 0;
    wire           ref_line = ref_clk_oe_n ? clock_in_pin : ref_clk_out;
    // {neg, abilities, pd100, pd10, up, speed100, full}
    logic [9:0]    rows [7] = '{10'h3E7, 10'h2E6, 10'h265, 10'h224, 10'h016, 10'h00C, 10'h000};

    // clocks
    initial begin
        clock = 1'b0;
        forever #10 clock = ~clock;
    end
    initial begin
        clock_in_pin = 1'b0;
        #7;
        forever #80 clock_in_pin = ~clock_in_pin;
    end

    rfp_phy_port dut_u (
        .clock, .rst, .ce(1'b1), .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
        .s_axi_wstrb(4'hF), .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
        .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
        .s_axi_rready, .clock_in_pin, .ref_clk_out, .ref_clk_oe_n, .txen, .txd, .crs_dv, .rxd, .rxer,
        .autoneg_speed_strap, .line_carrier, .line_rx_dv, .line_rx_dibit, .line_rx_err, .partner_neg,
        .partner_abil, .pd_100, .pd_10, .line_tx_en, .line_tx_dibit, .link_up, .link_speed100, .link_full
    );
    rfp_mac_model mac_u (
        .clock, .ref_clk(ref_line), .start(mac_start), .tx_word(mac_tx_word), .crs_dv, .rxd, .rxer,
        .txen, .txd, .rx_word(mac_rx_word), .rx_bad(mac_rx_bad), .col(mac_col)
    );

    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        checked++;
        if (got !== exp) begin
            error_cnt++;
            $display("[ERR] %s expected %h seen %h", nm, exp, got);
        end
    endtask

    task automatic print_verdict();
        $display("checks %0d mismatches %0d", checked, error_cnt);
        if (error_cnt == 0 && checked > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    // hang guard
    always @(posedge clock) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            error_cnt++;
            print_verdict();
        end
    end

    // bus write
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        bit aw;
        bit w;
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        while (!(aw && w)) begin
            @(posedge clock);
            if (s_axi_awvalid && s_axi_awready) begin
                aw = 1'b1;
                s_axi_awvalid <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w = 1'b1;
                s_axi_wvalid <= 1'b0;
            end
        end
        do @(posedge clock); while (s_axi_bvalid !== 1'b1);
        rsp = s_axi_bresp;
        s_axi_bready <= 1'b0;
        @(posedge clock);
    endtask

    task automatic rd_reg(input logic [7:0] a);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do @(posedge clock); while (s_axi_arready !== 1'b1);
        s_axi_arvalid <= 1'b0;
        do @(posedge clock); while (s_axi_rvalid !== 1'b1);
        rd = s_axi_rdata;
        rsp = s_axi_rresp;
        s_axi_rready <= 1'b0;
        @(posedge clock);
    endtask

    task automatic do_reset(input logic s);
        rst <= 1'b1;
        autoneg_speed_strap <= s;
        repeat (10) @(posedge clock);
        rst <= 1'b0;
        repeat (3) @(posedge clock);
    endtask

    // expects {up, speed100, full}
    task automatic link_chk(input logic [2:0] exp);
        repeat (4) @(posedge clock);
        chk("link", exp, {link_up, exp[2] ? {link_speed100, link_full} : 2'h0});
    endtask

    // mac frame seen at line
    task automatic tx_watch(input int per, input logic [15:0] w);
        logic [15:0] got;
        mac_tx_word <= w;
        mac_start <= 1'b1;
        @(posedge clock);
        mac_start <= 1'b0;
        while (line_tx_en !== 1'b1) @(posedge clock);
        for (int i = 0; i < 8; i++) begin
            got = {got[13:0], line_tx_dibit};
            repeat (per) @(posedge clock);
        end
        chk("line_tx", w, got);
        chk("line_tx_en", 1'b0, line_tx_en);
    endtask

    // line frame seen by mac
    task automatic rx_send(input int per, input logic [15:0] w, input logic e);
        logic c = 1'b0;
        line_carrier <= 1'b1;
        repeat (4 * per) begin
            @(posedge clock);
            c = c | (mac_col === 1'b1);
        end
        chk("crs_dv", 1'b1, crs_dv);
        chk("rxd_pre", 2'h0, rxd);
        chk("col", 1'b1, c);
        for (int i = 0; i < 8; i++) begin
            line_rx_dv <= 1'b1;
            line_rx_dibit <= w[15 - 2 * i -: 2];
            line_rx_err <= e && i == 3;
            if (i == 7) line_carrier <= 1'b0;
            repeat (per) @(posedge clock);
        end
        line_rx_dv <= 1'b0;
        line_rx_dibit <= 2'h0;
        line_rx_err <= 1'b0;
        repeat (4 * per) @(posedge clock);
        chk("rx_word", w, mac_rx_word);
        chk("rx_err", e, mac_rx_bad);
    endtask

    task automatic frame(input int per, input logic [15:0] w, input logic e);
        fork
            tx_watch(per, w);
            rx_send(per, ~w, e);
        join
    endtask

    // main sequence
    initial begin
        do_reset(1'b1);
        chk("ref_oe_n", 1'b0, ref_clk_oe_n);
        rd_reg(A_CTL);
        chk("ctrl0", `RFP_CTRL0_RST, rd);
        rd_reg(A_ADV);
        chk("advert", `RFP_ADV_RST, rd);
        rd_reg(A_CLK);
        chk("clkctl", 32'h0, rd);
        rd_reg(8'h08);
        chk("unmapped", `RFP_RESP_SLVERR, rsp);
        $display("test reset done");
        for (int i = 0; i < 7; i++) begin
            {partner_neg, partner_abil, pd_100, pd_10} <= 7'h00;
            repeat (4) @(posedge clock);
            {partner_neg, partner_abil, pd_100, pd_10} <= rows[i][9:3];
            link_chk(rows[i][2:0]);
        end
        $display("test modes done");
        wr(A_CTL, 32'h0100);
        link_chk(3'h5);
        wr(A_CTL, 32'h2000);
        link_chk(3'h6);
        rd_reg(A_ST);
        chk("status", 4'h3, {rd[`RFP_ST_REF50], rd[2:0]});
        wr(A_CTL, `RFP_CTRL0_RST);
        {partner_neg, partner_abil} <= 5'h1F;
        link_chk(3'h7);
        frame(2, 16'hB4E1, 1'b1);
        $display("test 25MHz frame done");
        wr(A_CLK, 32'h80);
        chk("ref_oe_n", 1'b1, ref_clk_oe_n);
        rd_reg(A_ST);
        chk("ref50", 1'b1, rd[`RFP_ST_REF50]);
        frame(8, 16'h1D72, 1'b0);
        $display("test 50MHz frame done");
        do_reset(1'b0);
        chk("ref_oe_n", 1'b0, ref_clk_oe_n);
        rd_reg(A_CTL);
        chk("ctrl0", `RFP_CTRL0_RST & ~32'h3000, rd);
        rd_reg(A_ADV);
        chk("advert", (`RFP_ADV_RST & 32'h1F) | (`RFP_ADV_10ONLY << `RFP_ADV_LSB), rd);
        link_chk(3'h5);
        $display("test strap low done");
        print_verdict();
    end
endmodule // testbench
